//--- logic/dac_channel.sv
`timescale 1ns/1ps
module dac_channel
  import dac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output dac_bus_t o_bus,
  output logic [15:0] o_bus_wdata,
  output logic o_bus_req,
  output logic o_bus_hold,
  input wire logic i_bus_done,
  input wire logic [15:0] i_bus_rdata,
  input wire logic i_dev_req_n,
  input wire logic i_dev_ready,
  output logic o_dev_ack,
  output logic o_terminal_count,
  input wire logic i_line_in,
  output logic o_line_out,
  output logic o_line_oe,
  input wire logic [5:0] i_am_strap
);

  logic [8:0] sync_q;
  logic [7:0] devctl_reg;
  logic [7:0] control_reg;
  logic cont_reg;
  logic complete_reg;
  logic block_reg;
  logic error_reg;
  logic event_reg;
  logic line_d_reg;
  logic armed_reg;
  logic [31:0] mptr_reg;
  logic [31:0] dptr_reg;
  logic [31:0] bptr_reg;
  logic [31:0] link_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [2:0] mfc_reg;
  logic [2:0] dfc_reg;
  logic [2:0] bfc_reg;
  logic [7:0] page_reg;
  logic [2:0] idx_reg;
  dac_state_t state_reg;

  logic req_on;
  logic ready_s;
  logic line_s;
  logic [5:0] strap_s;
  dac_req_mode_t req_mode;
  dac_kind_t kind;
  dac_line_t line_mode;
  dac_chain_t chain;
  logic dual;
  logic dir;
  logic [31:0] step;
  logic active;
  logic [1:0] lane;
  logic start_wr;
  logic abort;
  logic go;
  logic issue;
  logic cycle_done;
  logic fetch_done;
  logic fetch_last;
  logic last_op;
  logic op_end;
  logic more_chain;
  logic do_reload;
  logic finish;
  logic [31:0] ld_ptr;
  logic [2:0] ld_fc;
  logic ld_write;
  logic ld_word;
  logic status_clr;

  dac_sync #(.W(9)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_d({i_am_strap, i_line_in, i_dev_ready, i_dev_req_n}),
    .o_q(sync_q)
  );

  assign req_on = ~sync_q[0];
  assign ready_s = sync_q[1];
  assign line_s = sync_q[2];
  assign strap_s = sync_q[8:3];

  assign req_mode = dac_req_mode_t'(devctl_reg[DC_REQ_MODE_LSB +: 2]);
  assign kind = dac_kind_t'(devctl_reg[DC_KIND_LSB +: 2]);
  assign line_mode = dac_line_t'(devctl_reg[DC_LINE_LSB +: 2]);
  assign chain = dac_chain_t'(control_reg[CTL_CHAIN_LSB +: 2]);
  assign dir = control_reg[CTL_DIR_BIT];
  // explicitly addressed kinds need the device pointer on the bus
  assign dual = (kind == KIND_EXPL_A) | (kind == KIND_EXPL_B);
  assign step = devctl_reg[DC_PORT_WIDTH_BIT] ? 32'h2 : 32'h1;
  assign active = state_reg != ST_IDLE;
  assign lane = ~i_reg_addr[1:0];

  assign start_wr = i_reg_wr & (i_reg_addr == OFS_CONTROL)
                    & i_reg_wdata[CTL_START_BIT] & ~active & ~complete_reg;
  assign abort = active & (line_mode == LINE_ABORT) & ~line_s;
  // cycle steal needs the request to drop between operands
  assign go = req_on & ((kind != KIND_ACK_READY) | ready_s)
              & (armed_reg | (req_mode == REQ_BURST)
                 | (req_mode == REQ_RSVD));
  assign issue = ~o_bus_req & ~abort
                 & ((state_reg == ST_FETCH) | (state_reg == ST_SECOND)
                    | ((state_reg == ST_WAIT) & go));
  assign cycle_done = o_bus_req & i_bus_done;
  assign fetch_done = cycle_done & (state_reg == ST_FETCH);
  assign fetch_last = idx_reg == ((chain == CH_LINK) ? LINK_LAST_IDX
                                                     : ARRAY_LAST_IDX);
  assign last_op = count_reg == 16'h0001;
  assign op_end = (state_reg == ST_END) & ~abort;
  assign more_chain = ((chain == CH_ARRAY) & (reload_reg != 16'h0))
                      | ((chain == CH_LINK) & (link_reg != 32'h0));
  assign do_reload = op_end & last_op & ~more_chain & cont_reg;
  assign finish = op_end & last_op & ~more_chain & ~cont_reg;
  assign status_clr = i_reg_wr & (i_reg_addr == OFS_STATUS);

  // select which pointer and qualifier go out on the next bus cycle
  always_comb
  begin
    ld_ptr = mptr_reg;
    ld_fc = mfc_reg;
    ld_write = dir;
    ld_word = devctl_reg[DC_PORT_WIDTH_BIT];
    if (state_reg == ST_FETCH)
    begin
      ld_ptr = bptr_reg;
      ld_fc = bfc_reg;
      ld_write = 1'b0;
      ld_word = 1'b1;
    end
    else if (dual & ((state_reg == ST_SECOND) != dir))
    begin
      ld_ptr = dptr_reg;
      ld_fc = dfc_reg;
      ld_write = state_reg == ST_SECOND;
    end
    else if (dual)
    begin
      ld_write = state_reg == ST_SECOND;
    end
  end

  dac_amgen u_amgen (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_load(issue),
    .i_addr({page_reg, ld_ptr[23:0]}),
    .i_fc(ld_fc),
    .i_write(ld_write),
    .i_word(ld_word),
    .i_strap(strap_s),
    .o_bus(o_bus)
  );

  // flyby selects the device by acknowledge alone, no device address
  assign o_dev_ack = o_bus_req & ~dual & (state_reg == ST_FIRST);
  assign o_bus_hold = active & (req_mode == REQ_STEAL_HOLD);
  assign o_line_out = 1'b0;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_reg <= ST_IDLE;
      o_bus_req <= 1'b0;
      idx_reg <= 3'h0;
    end
    else if (abort)
    begin
      state_reg <= ST_IDLE;
      o_bus_req <= 1'b0;
      idx_reg <= 3'h0;
    end
    else
    begin
      if (issue)
        o_bus_req <= 1'b1;
      else if (cycle_done)
        o_bus_req <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
          if (start_wr)
          begin
            idx_reg <= 3'h0;
            state_reg <= i_reg_wdata[CTL_CHAIN_LSB + 1] ? ST_FETCH
                                                        : ST_WAIT;
          end
        ST_FETCH:
          if (cycle_done)
          begin
            idx_reg <= fetch_last ? 3'h0 : idx_reg + 3'h1;
            if (fetch_last)
              state_reg <= ST_WAIT;
          end
        ST_WAIT:
          if (issue)
            state_reg <= ST_FIRST;
        ST_FIRST:
          if (cycle_done)
            state_reg <= dual ? ST_SECOND : ST_END;
        ST_SECOND:
          if (cycle_done)
            state_reg <= ST_END;
        ST_END:
          if (!last_op)
            state_reg <= ST_WAIT;
          else if (more_chain)
            state_reg <= ST_FETCH;
          else if (cont_reg)
            state_reg <= ST_WAIT;
          else
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      armed_reg <= 1'b1;
    else if (issue & (state_reg == ST_WAIT))
      armed_reg <= 1'b0;
    else if (!req_on)
      armed_reg <= 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_bus_wdata <= 16'h0;
    else if (cycle_done & dual & (state_reg == ST_FIRST))
      o_bus_wdata <= i_bus_rdata;
  end

  // pointers: hardware updates take priority over register writes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      mptr_reg <= POINTER_RST;
      dptr_reg <= POINTER_RST;
    end
    else if (fetch_done & (idx_reg == 3'h0))
      mptr_reg[31:16] <= i_bus_rdata;
    else if (fetch_done & (idx_reg == 3'h1))
      mptr_reg[15:0] <= i_bus_rdata;
    else if (do_reload)
      mptr_reg <= bptr_reg;
    else if (op_end)
    begin
      mptr_reg <= mptr_reg + step;
      if (dual)
        dptr_reg <= dptr_reg + step;
    end
    else if (i_reg_wr & word_hit(i_reg_addr, OFS_MEMORY_POINTER))
      mptr_reg <= set_byte(mptr_reg, lane, i_reg_wdata);
    else if (i_reg_wr & word_hit(i_reg_addr, OFS_DEVICE_POINTER))
      dptr_reg <= set_byte(dptr_reg, lane, i_reg_wdata);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      bptr_reg <= POINTER_RST;
      link_reg <= POINTER_RST;
    end
    else if (fetch_done)
    begin
      if (fetch_last & (chain == CH_LINK))
        bptr_reg <= {link_reg[31:16], i_bus_rdata};
      else
        bptr_reg <= bptr_reg + TABLE_STEP;
      if (idx_reg == 3'h3)
        link_reg[31:16] <= i_bus_rdata;
      if (idx_reg == 3'h4)
        link_reg[15:0] <= i_bus_rdata;
    end
    else if (i_reg_wr & word_hit(i_reg_addr, OFS_BASE_POINTER))
      bptr_reg <= set_byte(bptr_reg, lane, i_reg_wdata);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      count_reg <= COUNT_RST;
      reload_reg <= COUNT_RST;
    end
    else
    begin
      if (fetch_done & (idx_reg == 3'h2))
        count_reg <= i_bus_rdata;
      else if (do_reload)
        count_reg <= reload_reg;
      else if (op_end)
        count_reg <= count_reg - 16'h1;
      else if (i_reg_wr & word_hit(i_reg_addr, OFS_COUNTDOWN))
        count_reg <= 16'(set_byte({16'h0, count_reg}, lane, i_reg_wdata));
      if (fetch_done & fetch_last & (chain == CH_ARRAY))
        reload_reg <= reload_reg - 16'h1;
      else if (i_reg_wr & word_hit(i_reg_addr, OFS_RELOAD_COUNT))
        reload_reg <= 16'(set_byte({16'h0, reload_reg}, lane, i_reg_wdata));
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      devctl_reg <= DEVICE_CONTROL_RST;
      control_reg <= CONTROL_RST;
      mfc_reg <= QUALIFIER_RST;
      dfc_reg <= QUALIFIER_RST;
      bfc_reg <= QUALIFIER_RST;
      page_reg <= PAGE_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == OFS_DEVICE_CONTROL)
        devctl_reg <= i_reg_wdata & DEVICE_CONTROL_MASK;
      if ((i_reg_addr == OFS_CONTROL) & ~active)
        control_reg <= i_reg_wdata & CONTROL_CFG_MASK;
      if (i_reg_addr == OFS_MEMORY_CYCLE_QUALIFIER)
        mfc_reg <= i_reg_wdata[2:0];
      if (i_reg_addr == OFS_DEVICE_CYCLE_QUALIFIER)
        dfc_reg <= i_reg_wdata[2:0];
      if (i_reg_addr == OFS_BASE_CYCLE_QUALIFIER)
        bfc_reg <= i_reg_wdata[2:0];
      if (i_reg_addr == OFS_PAGE)
        page_reg <= i_reg_wdata;
    end
  end

  // status: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      complete_reg <= 1'b0;
      block_reg <= 1'b0;
      error_reg <= 1'b0;
      event_reg <= 1'b0;
      line_d_reg <= 1'b1;
      cont_reg <= 1'b0;
      o_terminal_count <= 1'b0;
      o_line_oe <= 1'b0;
    end
    else
    begin
      complete_reg <= finish | abort
                      | (complete_reg & ~(status_clr & i_reg_wdata[7]));
      block_reg <= do_reload
                   | (block_reg & ~(status_clr & i_reg_wdata[6]));
      error_reg <= abort | (error_reg & ~(status_clr & i_reg_wdata[4]));
      event_reg <= ((line_mode == LINE_STATUS_EVENT) & line_d_reg & ~line_s)
                   | (event_reg & ~(status_clr & i_reg_wdata[1]));
      line_d_reg <= line_s;
      o_terminal_count <= finish;
      o_line_oe <= start_wr & (line_mode == LINE_START_PULSE);
      if (abort | do_reload)
        cont_reg <= 1'b0;
      else if (i_reg_wr & (i_reg_addr == OFS_CONTROL)
               & i_reg_wdata[CTL_CONTINUE_BIT] & (active | start_wr))
        cont_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 8'h00;
      if (i_reg_addr == OFS_STATUS)
        o_reg_rdata <= {complete_reg, block_reg, 1'b0, error_reg,
                        active, 1'b0, event_reg, line_s};
      if (i_reg_addr == OFS_DEVICE_CONTROL)
        o_reg_rdata <= devctl_reg;
      if (i_reg_addr == OFS_CONTROL)
        o_reg_rdata <= {active, cont_reg, 6'h0} | control_reg;
      if (word_hit(i_reg_addr, OFS_COUNTDOWN))
        o_reg_rdata <= get_byte({16'h0, count_reg}, lane);
      if (word_hit(i_reg_addr, OFS_MEMORY_POINTER))
        o_reg_rdata <= get_byte(mptr_reg, lane);
      if (word_hit(i_reg_addr, OFS_DEVICE_POINTER))
        o_reg_rdata <= get_byte(dptr_reg, lane);
      if (word_hit(i_reg_addr, OFS_RELOAD_COUNT))
        o_reg_rdata <= get_byte({16'h0, reload_reg}, lane);
      if (word_hit(i_reg_addr, OFS_BASE_POINTER))
        o_reg_rdata <= get_byte(bptr_reg, lane);
      if (i_reg_addr == OFS_MEMORY_CYCLE_QUALIFIER)
        o_reg_rdata <= {5'h0, mfc_reg};
      if (i_reg_addr == OFS_DEVICE_CYCLE_QUALIFIER)
        o_reg_rdata <= {5'h0, dfc_reg};
      if (i_reg_addr == OFS_BASE_CYCLE_QUALIFIER)
        o_reg_rdata <= {5'h0, bfc_reg};
      if (i_reg_addr == OFS_PAGE)
        o_reg_rdata <= page_reg;
    end
  end

endmodule : dac_channel

//--- logic/dac_pkg.sv
package dac_pkg;

  // byte offsets on the register port
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h07;
  localparam logic [7:0] OFS_COUNTDOWN = 8'h08;
  localparam logic [7:0] OFS_MEMORY_POINTER = 8'h0c;
  localparam logic [7:0] OFS_DEVICE_POINTER = 8'h14;
  localparam logic [7:0] OFS_RELOAD_COUNT = 8'h18;
  localparam logic [7:0] OFS_BASE_POINTER = 8'h1c;
  localparam logic [7:0] OFS_MEMORY_CYCLE_QUALIFIER = 8'h29;
  localparam logic [7:0] OFS_DEVICE_CYCLE_QUALIFIER = 8'h31;
  localparam logic [7:0] OFS_BASE_CYCLE_QUALIFIER = 8'h39;
  localparam logic [7:0] OFS_PAGE = 8'h40;

  // field positions
  localparam int DC_REQ_MODE_LSB = 6;
  localparam int DC_KIND_LSB = 4;
  localparam int DC_PORT_WIDTH_BIT = 3;
  localparam int DC_LINE_LSB = 0;
  localparam int CTL_START_BIT = 7;
  localparam int CTL_CONTINUE_BIT = 6;
  localparam int CTL_CHAIN_LSB = 2;
  localparam int CTL_DIR_BIT = 0;
  localparam int ST_COMPLETE_BIT = 7;
  localparam int ST_BLOCK_BIT = 6;
  localparam int ST_ERROR_BIT = 4;
  localparam int FC_PRIV_BIT = 2;
  localparam int FC_SPACE_BIT = 1;
  localparam int FC_AREA_BIT = 0;

  localparam logic [7:0] DEVICE_CONTROL_MASK = 8'hfb;
  localparam logic [7:0] CONTROL_CFG_MASK = 8'h0d;

  // reset values
  localparam logic [7:0] DEVICE_CONTROL_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] QUALIFIER_RST = 3'h0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [31:0] POINTER_RST = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // table entry: address hi, address lo, count [, link hi, link lo]
  localparam logic [2:0] ARRAY_LAST_IDX = 3'h2;
  localparam logic [2:0] LINK_LAST_IDX = 3'h4;
  localparam logic [31:0] TABLE_STEP = 32'h0000_0002;

  typedef enum logic [1:0] {
    REQ_BURST = 2'b00,
    REQ_RSVD = 2'b01,
    REQ_STEAL = 2'b10,
    REQ_STEAL_HOLD = 2'b11
  } dac_req_mode_t;

  typedef enum logic [1:0] {
    KIND_EXPL_A = 2'b00,
    KIND_EXPL_B = 2'b01,
    KIND_ACK = 2'b10,
    KIND_ACK_READY = 2'b11
  } dac_kind_t;

  typedef enum logic [1:0] {
    LINE_STATUS = 2'b00,
    LINE_STATUS_EVENT = 2'b01,
    LINE_START_PULSE = 2'b10,
    LINE_ABORT = 2'b11
  } dac_line_t;

  typedef enum logic [1:0] {
    CH_NONE = 2'b00,
    CH_RSVD = 2'b01,
    CH_ARRAY = 2'b10,
    CH_LINK = 2'b11
  } dac_chain_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_FIRST = 3'b011,
    ST_SECOND = 3'b100,
    ST_END = 3'b101
  } dac_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] fc;
    logic [5:0] am;
    logic write;
    logic word;
  } dac_bus_t;

  function automatic logic [5:0] am_code(input logic [2:0] fc,
                                         input logic [5:0] strap);
    logic [5:0] am;
    am[5:3] = fc[FC_SPACE_BIT] ? 3'h7 : 3'h5;
    am[2] = fc[FC_PRIV_BIT];
    am[1:0] = fc[FC_AREA_BIT] ? 2'h2 : 2'h1;
    // straps flip bits so any modifier can be reached
    am_code = am ^ strap;
  endfunction : am_code

  function automatic logic word_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    word_hit = addr[7:2] == ofs[7:2];
  endfunction : word_hit

  function automatic logic [31:0] set_byte(input logic [31:0] val,
                                           input logic [1:0] lane,
                                           input logic [7:0] data);
    logic [31:0] r;
    r = val;
    r[lane*8 +: 8] = data;
    set_byte = r;
  endfunction : set_byte

  function automatic logic [7:0] get_byte(input logic [31:0] val,
                                          input logic [1:0] lane);
    get_byte = val[lane*8 +: 8];
  endfunction : get_byte

endpackage : dac_pkg

//--- logic/dac_sync.sv
`timescale 1ns/1ps
module dac_sync
  import dac_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      meta_reg <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule : dac_sync

//--- logic/dac_amgen.sv
`timescale 1ns/1ps
module dac_amgen
  import dac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [31:0] i_addr,
  input wire logic [2:0] i_fc,
  input wire logic i_write,
  input wire logic i_word,
  input wire logic [5:0] i_strap,
  output dac_bus_t o_bus
);

  // address and qualifier are latched together so they never skew
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_bus <= '0;
    end
    else if (i_load)
    begin
      o_bus.addr <= i_addr;
      o_bus.fc <= i_fc;
      o_bus.am <= am_code(i_fc, i_strap);
      o_bus.write <= i_write;
      o_bus.word <= i_word;
    end
  end

endmodule : dac_amgen

//--- verif/dac_channel_props.sv
`timescale 1ns/1ps
module dac_channel_props
  import dac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire dac_bus_t o_bus,
  input wire logic [15:0] o_bus_wdata,
  input wire logic o_bus_req,
  input wire logic o_bus_hold,
  input wire logic i_bus_done,
  input wire logic [15:0] i_bus_rdata,
  input wire logic i_dev_req_n,
  input wire logic i_dev_ready,
  input wire logic o_dev_ack,
  input wire logic o_terminal_count,
  input wire logic i_line_in,
  input wire logic o_line_out,
  input wire logic o_line_oe,
  input wire logic [5:0] i_am_strap
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  logic [5:0] am_exp;
  // straps are held still by the bench, so the sync delay does not matter
  assign am_exp = {o_bus.fc[1] ? 3'h7 : 3'h5, o_bus.fc[2],
    o_bus.fc[0] ? 2'h2 : 2'h1} ^ i_am_strap;
  sequence s_cycle_end;
    o_bus_req && i_bus_done;
  endsequence
  sequence s_qual_read;
    i_reg_rd && i_reg_addr == OFS_MEMORY_CYCLE_QUALIFIER;
  endsequence
  chk_req_release: assert property (
    s_cycle_end |=> !o_bus_req) else $error("request held after done");
  chk_bus_steady: assert property (
    o_bus_req && !i_bus_done |=> $stable(o_bus) && o_bus_req)
    else $error("bus cycle changed before done");
  chk_am_code: assert property (
    o_bus_req |-> o_bus.am == am_exp) else $error("modifier code wrong");
  chk_ack_flyby: assert property (
    o_dev_ack |-> o_bus_req) else $error("ack outside a bus cycle");
  chk_tc_single: assert property (
    o_terminal_count |=> !o_terminal_count[*2]) else $error("tc too long");
  chk_tc_quiet: assert property (
    o_terminal_count |-> !o_bus_req) else $error("tc during bus cycle");
  chk_pulse_width: assert property (
    o_line_oe |=> !o_line_oe && !o_line_out) else $error("start pulse long");
  chk_qual_width: assert property (
    s_qual_read |=> o_reg_rdata[7:3] == 5'h00) else $error("qualifier wide");
  // shadow of request mode and port width, taken from the register writes
  logic [4:0] dc_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      dc_reg <= 5'h00;
    else if (i_reg_wr && i_reg_addr == OFS_DEVICE_CONTROL)
      dc_reg <= i_reg_wdata[7:3];
  end
  chk_hold_mode: assert property (
    o_bus_req |-> o_bus_hold == (dc_reg[4:3] == 2'b11))
    else $error("hold level wrong");
  chk_ack_width: assert property (
    o_dev_ack |-> o_bus.word == dc_reg[0]) else $error("flyby width wrong");
endmodule : dac_channel_props

bind dac_channel dac_channel_props dac_channel_props_inst (.i_ref_clk,
  .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_bus, .o_bus_wdata, .o_bus_req, .o_bus_hold, .i_bus_done, .i_bus_rdata,
  .i_dev_req_n, .i_dev_ready, .o_dev_ack, .o_terminal_count, .i_line_in,
  .o_line_out, .o_line_oe, .i_am_strap);

//--- verif/dac_mem_model.sv
`timescale 1ns/1ps
module dac_mem_model
  import dac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire dac_bus_t i_bus,
  input wire logic [15:0] i_wdata,
  input wire logic i_req,
  output logic o_done,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:255];
  int wait_cnt = 0;
  initial o_done = 1'b0;
  initial o_rdata = 16'h0000;
  // one answer per request; read data is not held once the cycle ends
  always @(posedge i_ref_clk)
  begin
    o_done <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_done)
      if (wait_cnt < (i_slow ? 3 : 0))
        wait_cnt <= wait_cnt + 1;
      else
      begin
        wait_cnt <= 0;
        o_done <= 1'b1;
        if (i_bus.write)
          mem[i_bus.addr[8:1]] <= i_wdata;
        else
          o_rdata <= mem[i_bus.addr[8:1]];
      end
  end
endmodule : dac_mem_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb
  import dac_pkg::*;
;
  logic i_ref_clk = 0, i_srst = 1, i_reg_wr = 0, i_reg_rd = 0, slow = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, rv;
  logic i_dev_req_n = 0, i_dev_ready = 0, i_line_in = 1, i_bus_done;
  logic o_bus_req, o_bus_hold, o_dev_ack, o_terminal_count, o_line_out;
  logic o_line_oe;
  logic [5:0] i_am_strap = 6'h00;
  logic [15:0] o_bus_wdata, i_bus_rdata;
  logic [31:0] seed = 32'h0000ac49, r;
  logic [2:0] mfc, dfc, bfc;
  logic [36:0] got_q[$], exp_q[$];
  dac_bus_t o_bus;
  int failures = 0, checks = 0, cyc = 0, tc_cnt = 0, oe_cnt = 0;

  dac_channel dac_channel_inst (.i_ref_clk, .i_srst, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_bus, .o_bus_wdata,
    .o_bus_req, .o_bus_hold, .i_bus_done, .i_bus_rdata, .i_dev_req_n,
    .i_dev_ready, .o_dev_ack, .o_terminal_count, .i_line_in, .o_line_out,
    .o_line_oe, .i_am_strap);
  dac_mem_model dac_mem_model_inst (.i_ref_clk, .i_slow(slow), .i_bus(o_bus),
    .i_wdata(o_bus_wdata), .i_req(o_bus_req), .o_done(i_bus_done),
    .o_rdata(i_bus_rdata));

  initial
  begin
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t register value %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_bus(input logic [36:0] got, input logic [36:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t bus cycle %h expected %h", $time, got, exp);
    end
  endtask : cmp_bus

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  // multi-byte registers go most significant byte first
  task automatic wrn(input logic [7:0] a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++)
      wr(a + 8'(i), v[(n - 1 - i) * 8 +: 8]);
  endtask : wrn

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 cmp_reg(o_reg_rdata, e);
  endtask : rd

  task automatic ex(input logic k, input logic [31:0] a, input logic w,
                    input logic [2:0] f);
    exp_q.push_back({k, a, w, f});
  endtask : ex

  task automatic run(input logic [7:0] ctl, input logic s);
    slow <= s;
    tc_cnt = 0;
    wr(OFS_CONTROL, ctl);
    for (int i = 0; i < 400 && tc_cnt == 0; i++)
      @(posedge i_ref_clk);
    repeat (4) @(posedge i_ref_clk);
    cmp_reg(8'(tc_cnt), 8'h01);
    cmp_reg(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i])
      cmp_bus(got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
  endtask : run

  always @(posedge i_ref_clk)
  begin
    cyc++;
    // device drops its request while acknowledged, re-arming cycle steal
    i_dev_req_n <= o_dev_ack;
    if (o_bus_req === 1'b1 && i_bus_done === 1'b1)
      got_q.push_back({o_dev_ack, o_bus.addr, o_bus.write, o_bus.fc});
    if (o_terminal_count === 1'b1)
      tc_cnt++;
    if (o_line_oe === 1'b1)
      oe_cnt++;
    if (cyc == 5000)
    begin
      failures++;
      finish_test();
    end
  end

  initial
  begin
    r = xs();
    i_am_strap = r[5:0];
    i_dev_ready = r[8];
    for (int i = 0; i < 256; i++)
    begin
      r = xs();
      dac_mem_model_inst.mem[i] = r[15:0];
    end
    repeat (5) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(OFS_DEVICE_CONTROL, 8'h00);
    rd(OFS_BASE_CYCLE_QUALIFIER, 8'h00);
    rd(OFS_PAGE, 8'h00);
    rd(8'h80, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      rv = {i[1:0], i[1:0], r[3:0]};
      wr(OFS_DEVICE_CONTROL, rv);
      rd(OFS_DEVICE_CONTROL, rv & 8'hfb);
    end
    r = xs();
    {mfc, dfc, bfc} = r[8:0];
    wr(OFS_MEMORY_CYCLE_QUALIFIER, {5'h1f, mfc});
    wr(OFS_DEVICE_CYCLE_QUALIFIER, {5'h15, dfc});
    wr(OFS_BASE_CYCLE_QUALIFIER, {5'h0a, bfc});
    rd(OFS_MEMORY_CYCLE_QUALIFIER, {5'h00, mfc});
    rd(OFS_DEVICE_CYCLE_QUALIFIER, {5'h00, dfc});
    rd(OFS_BASE_CYCLE_QUALIFIER, {5'h00, bfc});
    // flyby byte block in cycle steal with hold, then one continued block
    wr(OFS_DEVICE_CONTROL, 8'he0);
    wrn(OFS_MEMORY_POINTER, 32'h0000_0010, 4);
    wrn(OFS_COUNTDOWN + 8'h02, 32'h0000_0002, 2);
    wrn(OFS_BASE_POINTER, 32'h0000_0030, 4);
    wrn(OFS_RELOAD_COUNT + 8'h02, 32'h0000_0001, 2);
    ex(1'b1, 32'h0000_0010, 1'b1, mfc);
    ex(1'b1, 32'h0000_0011, 1'b1, mfc);
    ex(1'b1, 32'h0000_0030, 1'b1, mfc);
    run(8'hc1, 1'b0);
    rd(OFS_STATUS, 8'hc1);
    wr(OFS_STATUS, 8'hd2);
    // flowthrough word copy on a high page with a start pulse
    wr(OFS_PAGE, 8'h5a);
    wr(OFS_DEVICE_CONTROL, 8'h0a);
    wrn(OFS_MEMORY_POINTER, 32'h0000_0040, 4);
    wrn(OFS_DEVICE_POINTER, 32'h0000_0080, 4);
    wrn(OFS_COUNTDOWN + 8'h02, 32'h0000_0002, 2);
    for (int i = 0; i < 4; i += 2)
    begin
      ex(1'b0, 32'h5a00_0040 + 32'(i), 1'b0, mfc);
      ex(1'b0, 32'h5a00_0080 + 32'(i), 1'b1, dfc);
    end
    oe_cnt = 0;
    run(8'h80, 1'b1);
    cmp_reg(8'(oe_cnt), 8'h01);
    r = {dac_mem_model_inst.mem[8'h40], dac_mem_model_inst.mem[8'h41]};
    cmp_bus(37'(r), 37'({dac_mem_model_inst.mem[8'h20],
      dac_mem_model_inst.mem[8'h21]}));
    wr(OFS_STATUS, 8'hd2);
    // array chain of one entry read through the base pointer
    wr(OFS_PAGE, 8'h00);
    wr(OFS_DEVICE_CONTROL, 8'h20);
    wrn(OFS_BASE_POINTER, 32'h0000_00a0, 4);
    wrn(OFS_RELOAD_COUNT + 8'h02, 32'h0000_0001, 2);
    dac_mem_model_inst.mem[8'h50] = 16'h0000;
    dac_mem_model_inst.mem[8'h51] = 16'h0060;
    dac_mem_model_inst.mem[8'h52] = 16'h0002;
    for (int i = 0; i < 6; i += 2)
      ex(1'b0, 32'h0000_00a0 + 32'(i), 1'b0, bfc);
    ex(1'b1, 32'h0000_0060, 1'b0, mfc);
    ex(1'b1, 32'h0000_0061, 1'b0, mfc);
    run(8'h88, 1'b1);
    finish_test();
  end
endmodule : tb
